// [logic/cqm_top.sv]
// Channel quality monitor: register file, window timer and result scaling
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cqm_map.svh"
module cqm_top #(
  parameter int WINDOW_SYMBOLS = `CQM_WINDOW_SYMBOLS
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sample_valid_in,
  input wire logic speed_1000_in,
  input wire logic [31:0] slicer_err_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out
);
  cqm_cfg_if cfg_bus ();
  logic [31:0] cfg_reg, cfg_next;
  logic [8:0] thr_reg [1:7];
  logic [8:0] thr_next [1:7];
  logic [16:0] win_cnt_reg, win_cnt_next;
  cqm_pkg::cqm_index_t idx_cur_reg, idx_cur_next, idx_worst_reg, idx_worst_next;
  logic idx_wv_reg, idx_wv_next;
  cqm_pkg::cqm_err_t mean_res_reg, mean_res_next;
  logic [8:0] mse_res_reg, mse_res_next;
  logic [5:0] pk_cur_reg, pk_cur_next, pk_worst_reg, pk_worst_next;
  logic pk_wv_reg, pk_wv_next;
  logic [31:0] rdata_reg, rdata_next;
  cqm_pkg::cqm_err_t mean_snap [0:3];
  cqm_pkg::cqm_err_t peak_snap [0:3];
  cqm_pkg::cqm_err_t sel_mean, sel_peak, mean_sh, peak_sh;
  logic [4:0] peak_amt;
  logic [8:0] mse_calc;
  logic [5:0] pk_calc;
  cqm_pkg::cqm_index_t idx_calc;
  logic capture, enable, tick;

  assign enable = cfg_reg[`CQM_B_ENABLE];
  assign tick = sample_valid_in && (win_cnt_reg == 17'(WINDOW_SYMBOLS - 1));
  assign capture = wr_in && (addr_in == `CQM_OFS_CFG) && wdata_in[`CQM_B_CAPTURE];

  // Settings handed to all four pair filters
  assign cfg_bus.enable = enable;
  assign cfg_bus.square_mode = cfg_reg[`CQM_B_SQUARE];
  assign cfg_bus.is_1000 = speed_1000_in;
  assign cfg_bus.sample_valid = sample_valid_in;
  assign cfg_bus.window_tick = tick;
  assign cfg_bus.mean_filter_gain_shift = cfg_reg[`CQM_F_MEAN_GAIN];
  assign cfg_bus.peak_filter_gain_shift = cfg_reg[`CQM_F_PEAK_GAIN];

  // One filter unit per cable pair
  for (genvar p = 0; p < 4; p++) begin : g_pair
    cqm_pair_filter u_filt (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .cfg(cfg_bus),
      .slicer_err_in(slicer_err_in[p*8 +: 8]),
      .mean_snap_out(mean_snap[p]),
      .peak_snap_out(peak_snap[p])
    );
  end

  // Scaling and index mapping for the selected pair
  always_comb begin
    // Pair comes from the capture write itself, shifts from the settings
    // already held; software programs shifts one write ahead of a capture
    sel_mean = mean_snap[wdata_in[`CQM_F_PAIR]];
    sel_peak = peak_snap[wdata_in[`CQM_F_PAIR]];
    mean_sh = sel_mean >> cfg_reg[`CQM_F_MEAN_SHIFT];
    mse_calc = (mean_sh > 15'(`CQM_MSE_MAX)) ? `CQM_MSE_MAX : mean_sh[8:0];
    peak_amt = {1'b0, cfg_reg[`CQM_F_PEAK_SHIFT]} + `CQM_PEAK_EXTRA_SHIFT;
    peak_sh = sel_peak >> peak_amt;
    pk_calc = (peak_sh > 15'(`CQM_PEAK_MAX)) ? `CQM_PEAK_MAX : peak_sh[5:0];
    idx_calc = 3'h0;
    // Thresholds are expected to fall from one to seven; highest match wins
    for (int k = 1; k <= 7; k++) begin
      if (mse_calc <= thr_reg[k]) begin
        idx_calc = 3'(k);
      end
    end
  end

  // Window counter runs on symbols only while enabled
  always_comb begin
    win_cnt_next = win_cnt_reg;
    // Restarting on disable keeps every window aligned to the enable write
    if (!enable) begin
      win_cnt_next = 17'h00000;
    end else if (sample_valid_in) begin
      win_cnt_next = tick ? 17'h00000 : 17'(win_cnt_reg + 17'h00001);
    end
  end

  // Register writes, captures and read-side effects
  always_comb begin
    cfg_next = cfg_reg;
    thr_next = thr_reg;
    idx_cur_next = idx_cur_reg;
    idx_worst_next = idx_worst_reg;
    idx_wv_next = idx_wv_reg;
    mean_res_next = mean_res_reg;
    mse_res_next = mse_res_reg;
    pk_cur_next = pk_cur_reg;
    pk_worst_next = pk_worst_reg;
    pk_wv_next = pk_wv_reg;
    // Upper configuration bits are not implemented and read back as zero
    if (wr_in && addr_in == `CQM_OFS_CFG) begin
      cfg_next = wdata_in;
      cfg_next[`CQM_B_CAPTURE] = 1'b0;
      cfg_next[31:21] = 11'h000;
    end
    for (int k = 1; k <= 7; k++) begin
      if (wr_in && addr_in == 8'(`CQM_OFS_THR1 + 4 * (k - 1))) begin
        thr_next[k] = wdata_in[8:0];
      end
    end
    // A read only clears the valid flag; a capture never shares its cycle
    if (rd_in && addr_in == `CQM_OFS_INDEX) begin
      idx_wv_next = 1'b0;
    end
    if (rd_in && addr_in == `CQM_OFS_PEAK) begin
      pk_wv_next = 1'b0;
    end
    // Capture only while measuring; otherwise old results stay put
    if (capture && enable) begin
      idx_cur_next = idx_calc;
      mean_res_next = sel_mean;
      mse_res_next = mse_calc;
      pk_cur_next = pk_calc;
      if (!idx_wv_reg || idx_calc < idx_worst_reg) begin
        idx_worst_next = idx_calc;
      end
      if (!pk_wv_reg || pk_calc > pk_worst_reg) begin
        pk_worst_next = pk_calc;
      end
      idx_wv_next = 1'b1;
      pk_wv_next = 1'b1;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        `CQM_OFS_CFG: rdata_next = cfg_reg;
        `CQM_OFS_INDEX: rdata_next = {25'h0000000, idx_worst_reg, 1'b0, idx_cur_reg};
        `CQM_OFS_MEAN: rdata_next = {17'h00000, mean_res_reg};
        `CQM_OFS_MSE: rdata_next = {23'h000000, mse_res_reg};
        `CQM_OFS_PEAK: rdata_next = {18'h00000, pk_worst_reg, 2'h0, pk_cur_reg};
        default: begin
          // Threshold words sit at aligned offsets one to seven
          if (addr_in >= `CQM_OFS_THR1 && addr_in <= `CQM_OFS_THR7 && addr_in[1:0] == 2'h0) begin
            rdata_next = {23'h000000, thr_reg[3'(((addr_in - `CQM_OFS_THR1) >> 2) + 8'h01)]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cfg_reg <= `CQM_CFG_RESET;
      for (int k = 1; k <= 7; k++) begin
        thr_reg[k] <= `CQM_THR_RESET;
      end
      win_cnt_reg <= 17'h00000;
      idx_cur_reg <= 3'h0;
      idx_worst_reg <= 3'h0;
      idx_wv_reg <= 1'b0;
      mean_res_reg <= 15'h0000;
      mse_res_reg <= 9'h000;
      pk_cur_reg <= 6'h00;
      pk_worst_reg <= 6'h00;
      pk_wv_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      thr_reg <= thr_next;
      win_cnt_reg <= win_cnt_next;
      idx_cur_reg <= idx_cur_next;
      idx_worst_reg <= idx_worst_next;
      idx_wv_reg <= idx_wv_next;
      mean_res_reg <= mean_res_next;
      mse_res_reg <= mse_res_next;
      pk_cur_reg <= pk_cur_next;
      pk_worst_reg <= pk_worst_next;
      pk_wv_reg <= pk_wv_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_capture_self_clear: assert property (capture |=> !cfg_reg[`CQM_B_CAPTURE])
    else $error("Capture bit did not self-clear");
  a_capture_latch: assert property (capture && enable |=> idx_cur_reg == $past(idx_calc)
    && mean_res_reg == $past(sel_mean) && pk_cur_reg == $past(pk_calc))
    else $error("Capture did not latch selected pair");
  a_index_best: assert property (mse_calc <= thr_reg[7] |-> idx_calc == 3'h7)
    else $error("Index not 7 at or below threshold seven");
  a_index_worst: assert property (mse_calc > thr_reg[1] |-> idx_calc == 3'h0)
    else $error("Index not 0 above threshold one");
  a_mse_saturate: assert property (mean_sh > 15'h01ff |-> mse_calc == 9'h1ff)
    else $error("Scaled error did not saturate at 511");
  a_peak_saturate: assert property (peak_sh > 15'h003f |-> pk_calc == 6'h3f)
    else $error("Scaled peak did not saturate at 63");
  a_worst_index: assert property (idx_wv_reg |-> idx_worst_reg <= idx_cur_reg)
    else $error("Worst index above current");
  a_worst_peak: assert property (pk_wv_reg |-> pk_worst_reg >= pk_cur_reg)
    else $error("Worst peak below current");
  a_read_restart: assert property (!idx_wv_reg && capture && enable
    |=> idx_worst_reg == idx_cur_reg) else $error("Worst index not restarted after read");
  a_window_tick: assert property (tick |-> win_cnt_reg == 17'(WINDOW_SYMBOLS - 1))
    else $error("Window tick at wrong count");
  a_disabled_idle: assert property (!enable |=> win_cnt_reg == 17'h00000)
    else $error("Window counter ran while disabled");
  a_read_one_cycle: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
    else $error("Read data outside its cycle");

  // A capture while measuring is off must leave every result alone
  a_capture_disabled: assert property (capture && !enable |=> $stable(idx_cur_reg)
    && $stable(mean_res_reg) && $stable(mse_res_reg) && $stable(pk_cur_reg)
    && $stable(idx_worst_reg) && $stable(pk_worst_reg))
    else $error("Capture changed results while disabled");
  // Scaled results are linear below their ceilings and land with the capture
  a_mse_latch: assert property (capture && enable |=> mse_res_reg == $past(mse_calc))
    else $error("Scaled error not latched on capture");
  a_mse_linear: assert property (mean_sh <= 15'h01ff |-> mse_calc == mean_sh[8:0])
    else $error("Scaled error not linear below 511");
  a_peak_linear: assert property (peak_sh <= 15'h003f |-> pk_calc == peak_sh[5:0])
    else $error("Scaled peak not linear below 63");
  // The pair number of the capture write picks the filter unit
  a_mean_pair_select: assert property (capture && enable
    |=> mean_res_reg == $past(mean_snap[wdata_in[`CQM_F_PAIR]]))
    else $error("Mean result not taken from selected pair");
  // Worst fields move only towards a worse value while tracking
  a_worst_index_hold: assert property (idx_wv_reg && capture && enable
    && idx_calc >= idx_worst_reg |=> $stable(idx_worst_reg))
    else $error("Worst index moved on a better value");
  a_worst_peak_hold: assert property (pk_wv_reg && capture && enable
    && pk_calc <= pk_worst_reg |=> $stable(pk_worst_reg))
    else $error("Worst peak moved on a smaller value");
  // A read drops the worst flag so that the next capture restarts tracking
  a_read_clears_index: assert property (rd_in && addr_in == `CQM_OFS_INDEX
    |=> !idx_wv_reg) else $error("Worst index flag survived a read");
  a_read_clears_peak: assert property (rd_in && addr_in == `CQM_OFS_PEAK
    |=> !pk_wv_reg) else $error("Worst peak flag survived a read");
  a_peak_restart: assert property (!pk_wv_reg && capture && enable
    |=> pk_worst_reg == pk_cur_reg) else $error("Worst peak not restarted after read");
  // Window counter never passes the last symbol of a window
  a_window_range: assert property (win_cnt_reg < 17'(WINDOW_SYMBOLS))
    else $error("Window counter beyond window length");
  // Writes land as written, capture bit and unused bits excepted
  a_cfg_write: assert property (wr_in && addr_in == `CQM_OFS_CFG |=> cfg_reg ==
    {11'h000, $past(wdata_in[20:3]), 1'b0, $past(wdata_in[1:0])})
    else $error("Configuration write not taken as written");
  a_thr_one_write: assert property (wr_in && addr_in == `CQM_OFS_THR1
    |=> thr_reg[1] == $past(wdata_in[8:0])) else $error("Threshold one write lost");
  a_thr_seven_write: assert property (wr_in && addr_in == `CQM_OFS_THR7
    |=> thr_reg[7] == $past(wdata_in[8:0])) else $error("Threshold seven write lost");
  // Read data carries the register as it stood at the read strobe
  a_read_cfg: assert property (rd_in && addr_in == `CQM_OFS_CFG
    |=> rdata_out == $past(cfg_reg)) else $error("Configuration read wrong");
  a_read_index: assert property (rd_in && addr_in == `CQM_OFS_INDEX
    |=> rdata_out == {25'h0000000, $past(idx_worst_reg), 1'b0, $past(idx_cur_reg)})
    else $error("Index read wrong");
  a_read_mean: assert property (rd_in && addr_in == `CQM_OFS_MEAN
    |=> rdata_out == {17'h00000, $past(mean_res_reg)}) else $error("Mean result read wrong");
  a_read_mse: assert property (rd_in && addr_in == `CQM_OFS_MSE
    |=> rdata_out == {23'h000000, $past(mse_res_reg)}) else $error("Scaled error read wrong");
  a_read_peak: assert property (rd_in && addr_in == `CQM_OFS_PEAK
    |=> rdata_out == {18'h00000, $past(pk_worst_reg), 2'h0, $past(pk_cur_reg)})
    else $error("Peak read wrong");

  c_capture: cover property (capture && enable);
  c_window: cover property (tick && enable);
  c_worst_restart: cover property (rd_in && addr_in == `CQM_OFS_PEAK ##1 capture && enable);
  c_index_seven: cover property (capture && enable && idx_calc == 3'h7);
  c_disabled_capture: cover property (capture && !enable);
endmodule

// [logic/cqm_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef CQM_MAP_SVH
`define CQM_MAP_SVH
`define CQM_OFS_CFG 8'h00
`define CQM_OFS_THR1 8'h04
`define CQM_OFS_THR7 8'h1c
`define CQM_OFS_INDEX 8'h20
`define CQM_OFS_MEAN 8'h24
`define CQM_OFS_MSE 8'h28
`define CQM_OFS_PEAK 8'h2c
`define CQM_B_ENABLE 0
`define CQM_B_SQUARE 1
`define CQM_B_CAPTURE 2
`define CQM_F_PAIR 4:3
`define CQM_F_MEAN_GAIN 8:5
`define CQM_F_PEAK_GAIN 12:9
`define CQM_F_MEAN_SHIFT 16:13
`define CQM_F_PEAK_SHIFT 20:17
`define CQM_CFG_RESET 32'h0000_0000
`define CQM_THR_RESET 9'h000
`define CQM_MSE_MAX 9'h1ff
`define CQM_PEAK_MAX 6'h3f
`define CQM_PEAK_EXTRA_SHIFT 5'h03
`define CQM_LIMIT_1000 8'sh20
`define CQM_LIMIT_100 8'sh40
`define CQM_WINDOW_MS 1.0
`define CQM_WINDOW_SYMBOLS 125000
`endif

// [logic/cqm_pkg.sv]
// Shared types of the channel quality monitor
package cqm_pkg;
  typedef logic [14:0] cqm_err_t;
  typedef logic [3:0] cqm_shift_t;
  typedef logic [1:0] cqm_pair_t;
  typedef logic [2:0] cqm_index_t;
endpackage

// [logic/cqm_cfg_if.sv]
// Configuration and timing shared by the per-pair filter units
`timescale 1ns/1ps
interface cqm_cfg_if;
  logic enable;
  logic square_mode;
  logic is_1000;
  logic sample_valid;
  logic window_tick;
  cqm_pkg::cqm_shift_t mean_filter_gain_shift;
  cqm_pkg::cqm_shift_t peak_filter_gain_shift;
  modport ctrl (output enable, square_mode, is_1000, sample_valid, window_tick,
    mean_filter_gain_shift, peak_filter_gain_shift);
  modport unit (input enable, square_mode, is_1000, sample_valid, window_tick,
    mean_filter_gain_shift, peak_filter_gain_shift);
endinterface

// [logic/cqm_pair_filter.sv]
// Mean and peak error filters with 1 ms snapshots for one cable pair
`timescale 1ns/1ps
`include "cqm_map.svh"
module cqm_pair_filter (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  cqm_cfg_if.unit cfg,
  input wire logic signed [7:0] slicer_err_in,
  output cqm_pkg::cqm_err_t mean_snap_out,
  output cqm_pkg::cqm_err_t peak_snap_out
);
  logic [22:0] mean_f_reg, mean_f_next;
  logic [22:0] peak_f_reg, peak_f_next;
  cqm_pkg::cqm_err_t peak_max_reg, peak_max_next;
  cqm_pkg::cqm_err_t mean_snap_reg, mean_snap_next;
  cqm_pkg::cqm_err_t peak_snap_reg, peak_snap_next;
  logic signed [7:0] limit, err_b;
  logic [6:0] err_abs;
  logic [7:0] err_x;
  cqm_pkg::cqm_err_t err_sq, mean_in, peak_int, win_max;

  // First-order low-pass in 15.8 fixed point; fraction avoids a dead zone
  function automatic logic [22:0] lp_step(input logic [22:0] f, input cqm_pkg::cqm_err_t x,
                                          input cqm_pkg::cqm_shift_t sh);
    logic signed [23:0] diff;
    logic signed [23:0] sum;
    diff = $signed({1'b0, x, 8'h00}) - $signed({1'b0, f});
    sum = $signed({1'b0, f}) + (diff >>> sh);
    return sum[22:0];
  endfunction

  // Bound, rectify, scale and square the slicer error
  always_comb begin
    limit = cfg.is_1000 ? `CQM_LIMIT_1000 : `CQM_LIMIT_100;
    if (slicer_err_in > limit) begin
      err_b = limit;
    end else if (slicer_err_in < -limit) begin
      err_b = -limit;
    end else begin
      err_b = slicer_err_in;
    end
    err_abs = err_b[7] ? 7'(-err_b) : err_b[6:0];
    err_x = cfg.is_1000 ? {err_abs, 1'b0} : {1'b0, err_abs};
    err_sq = {7'h00, err_x} * {7'h00, err_x}; // Widened first so the square never wraps
    mean_in = cfg.square_mode ? err_sq : {7'h00, err_x};
  end

  // Filter, window maximum and snapshot next values
  always_comb begin
    peak_int = peak_f_reg[22:8];
    win_max = (peak_int > peak_max_reg) ? peak_int : peak_max_reg;
    mean_f_next = mean_f_reg;
    peak_f_next = peak_f_reg;
    peak_max_next = peak_max_reg;
    mean_snap_next = mean_snap_reg;
    peak_snap_next = peak_snap_reg;
    if (!cfg.enable) begin
      mean_f_next = 23'h000000;
      peak_f_next = 23'h000000;
      peak_max_next = 15'h0000;
      mean_snap_next = 15'h0000;
      peak_snap_next = 15'h0000;
    end else if (cfg.sample_valid) begin
      mean_f_next = lp_step(mean_f_reg, mean_in, cfg.mean_filter_gain_shift);
      peak_f_next = lp_step(peak_f_reg, err_sq, cfg.peak_filter_gain_shift);
      peak_max_next = win_max;
      if (cfg.window_tick) begin
        mean_snap_next = mean_f_reg[22:8];
        peak_snap_next = win_max;
        peak_max_next = 15'h0000;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mean_f_reg <= 23'h000000;
      peak_f_reg <= 23'h000000;
      peak_max_reg <= 15'h0000;
      mean_snap_reg <= 15'h0000;
      peak_snap_reg <= 15'h0000;
    end else begin
      mean_f_reg <= mean_f_next;
      peak_f_reg <= peak_f_next;
      peak_max_reg <= peak_max_next;
      mean_snap_reg <= mean_snap_next;
      peak_snap_reg <= peak_snap_next;
    end
  end

  assign mean_snap_out = mean_snap_reg;
  assign peak_snap_out = peak_snap_reg;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_disabled_results_zero: assert property (!cfg.enable |=> mean_snap_reg == 15'h0000
    && peak_snap_reg == 15'h0000) else $error("Results not cleared while disabled");
  a_error_bounded: assert property (err_abs <= (cfg.is_1000 ? 7'h20 : 7'h40))
    else $error("Slicer error exceeds bound");
  a_peak_window_max: assert property (cfg.enable && cfg.sample_valid && cfg.window_tick
    |=> peak_snap_reg >= $past(peak_int) && peak_snap_reg >= $past(peak_max_reg))
    else $error("Peak snapshot below window maximum");
  a_mean_held_off_tick: assert property (cfg.enable && !(cfg.sample_valid && cfg.window_tick)
    |=> $stable(mean_snap_reg)) else $error("Mean snapshot moved between ticks");
endmodule

// [verification/cqm_tb_top.sv]
// Self-checking bench for the channel quality monitor top
`timescale 1ns/1ps
`include "cqm_map.svh"
module cqm_tb_top;
  // Short window keeps the run brief; all expectations use it
  localparam int W = 16;
  localparam int TMAX = 20000;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sample_valid_in = 1'b0;
  logic speed_1000_in = 1'b0;
  logic [31:0] slicer_err_in = 32'h0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int e_idx;
  int e_raw;
  int e_mse;
  int e_pk;
  int thr [1:7];
  logic [31:0] seed = 32'haeb8d208;
  logic [31:0] d;
  logic [31:0] r;
  logic [31:0] errs;
  logic [7:0] tab [8] = '{8'h40, 8'h39, 8'h34, 8'h30, 8'h2a, 8'h24, 8'h1e, 8'h14};
  logic [7:0] ra [8] = '{`CQM_OFS_CFG, `CQM_OFS_THR1, `CQM_OFS_INDEX, `CQM_OFS_MEAN,
    `CQM_OFS_MSE, `CQM_OFS_PEAK, 8'h30, 8'h02};

  cqm_top #(.WINDOW_SYMBOLS(W)) dut (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .sample_valid_in(sample_valid_in),
    .speed_1000_in(speed_1000_in),
    .slicer_err_in(slicer_err_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out)
  );

  // 100 MHz clock
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  // Hang guard, well above the expected run of about 1500 cycles
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == TMAX) begin
      n_errors++;
      $display("[FAIL] %0t run did not finish in time", $time);
      conclude();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Bounded magnitude, doubled at gigabit
  function automatic int e2(logic spd, logic [7:0] e);
    int a;
    int b;
    a = int'($signed(e));
    if (a < 0) a = -a;
    b = spd ? 32 : 64;
    if (a > b) a = b;
    return spd ? 2 * a : a;
  endfunction

  // Add-back low-pass, 8 fraction bits, integer part returned
  function automatic int filt(int x, int g, int n);
    int f;
    f = 0;
    for (int i = 0; i < n; i++) begin
      f += ((x <<< 8) - f) >>> g;
    end
    return f >>> 8;
  endfunction

  function automatic int sat(int v, int m);
    return (v > m) ? m : v;
  endfunction

  // Assumes thresholds fall from one to seven
  function automatic int idx_of(int s);
    for (int k = 7; k >= 1; k--) begin
      if (s <= thr[k]) return k;
    end
    return 0;
  endfunction

  function automatic logic [31:0] cfgw(logic en, logic sq, logic cap, logic [1:0] p,
      logic [3:0] mg, logic [3:0] pg, logic [3:0] ms, logic [3:0] ps);
    logic [31:0] w;
    w = 32'h0;
    w[`CQM_B_ENABLE] = en;
    w[`CQM_B_SQUARE] = sq;
    w[`CQM_B_CAPTURE] = cap;
    w[`CQM_F_PAIR] = p;
    w[`CQM_F_MEAN_GAIN] = mg;
    w[`CQM_F_PEAK_GAIN] = pg;
    w[`CQM_F_MEAN_SHIFT] = ms;
    w[`CQM_F_PEAK_SHIFT] = ps;
    return w;
  endfunction

  // One-cycle write strobe; a gap cycle before the next access
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // Read data sampled only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Constant errors for two windows, then capture; shifts set one write earlier
  task automatic measure(input logic spd, input logic sq, input logic [1:0] p,
      input logic [31:0] ev, input logic [3:0] mg, input logic [3:0] pg,
      input logic [3:0] ms, input logic [3:0] ps);
    int x;
    x = e2(spd, ev[8 * p +: 8]);
    wr(`CQM_OFS_CFG, 32'h0);
    speed_1000_in <= spd;
    slicer_err_in <= ev;
    wr(`CQM_OFS_CFG, cfgw(1'b1, sq, 1'b0, p, mg, pg, ms, ps));
    repeat (2 * W) begin
      @(posedge mclk_in);
      sample_valid_in <= 1'b1;
    end
    @(posedge mclk_in);
    sample_valid_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    wr(`CQM_OFS_CFG, cfgw(1'b1, sq, 1'b1, p, mg, pg, ms, ps));
    e_raw = filt(sq ? x * x : x, int'(mg), 2 * W - 1);
    e_mse = sat(e_raw >> ms, 511);
    e_idx = idx_of(e_mse);
    e_pk = sat(filt(x * x, int'(pg), 2 * W - 1) >> (ps + 3), 63);
  endtask

  // Worst fields equal current when the previous capture followed a read
  task automatic check_cur();
    rd(`CQM_OFS_INDEX, d);
    chk({26'h0, d[6:4], d[2:0]}, {26'h0, 3'(e_idx), 3'(e_idx)});
    rd(`CQM_OFS_MEAN, d);
    chk(d, 32'(e_raw));
    rd(`CQM_OFS_MSE, d);
    chk(d, 32'(e_mse));
    rd(`CQM_OFS_PEAK, d);
    chk({20'h0, d[13:8], d[5:0]}, {20'h0, 6'(e_pk), 6'(e_pk)});
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    // Reset values and unmapped places read zero
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], d);
      chk(d, 32'h0);
    end
    // Falling thresholds, one per index step
    for (int k = 1; k <= 7; k++) begin
      thr[k] = 512 - 64 * k;
      wr(`CQM_OFS_THR1 + 8'(4 * (k - 1)), 32'(thr[k]));
    end
    wr(8'h30, 32'h1ff);
    rd(8'h30, d);
    chk(d, 32'h0);
    rd(`CQM_OFS_THR7, d);
    chk(d, 32'h40);
    // Capture bit never reads back
    wr(`CQM_OFS_CFG, cfgw(1'b0, 1'b1, 1'b1, 2'h2, 4'h1, 4'h2, 4'h3, 4'h4));
    rd(`CQM_OFS_CFG, d);
    chk(d, cfgw(1'b0, 1'b1, 1'b0, 2'h2, 4'h1, 4'h2, 4'h3, 4'h4));
    // Every index value once, other pairs random
    for (int k = 0; k < 8; k++) begin
      errs = xs();
      errs[8 * (k % 4) +: 8] = tab[k];
      measure(1'b0, 1'b1, 2'(k % 4), errs, 4'h0, 4'h0, 4'h3, 4'h0);
      check_cur();
    end
    // Worst index and worst peak held across two captures without a read
    measure(1'b0, 1'b1, 2'h1, {4{8'h40}}, 4'h0, 4'h0, 4'h3, 4'h0);
    measure(1'b0, 1'b1, 2'h1, {4{8'h14}}, 4'h0, 4'h0, 4'h3, 4'h0);
    rd(`CQM_OFS_INDEX, d);
    chk({26'h0, d[6:4], d[2:0]}, {26'h0, 3'h0, 3'(e_idx)});
    rd(`CQM_OFS_PEAK, d);
    chk({20'h0, d[13:8], d[5:0]}, {20'h0, 6'h3f, 6'(e_pk)});
    rd(`CQM_OFS_INDEX, d);
    chk({26'h0, d[6:4], d[2:0]}, {26'h0, 3'h0, 3'(e_idx)});
    measure(1'b0, 1'b1, 2'h0, {4{8'h14}}, 4'h0, 4'h0, 4'h3, 4'h0);
    check_cur();
    // Mean and peak gains act independently
    measure(1'b1, 1'b1, 2'h2, {4{8'he0}}, 4'hf, 4'h0, 4'h0, 4'h0);
    check_cur();
    measure(1'b1, 1'b0, 2'h3, {4{8'h20}}, 4'h0, 4'hf, 4'h0, 4'h0);
    check_cur();
    // Random speed, mode, pair, errors over the full byte range, mean gain and both shifts
    repeat (16) begin
      r = xs();
      measure(r[0], r[1], r[3:2], xs(), r[7:4], 4'h0, r[11:8], r[15:12]);
      check_cur();
    end
    // Capture while disabled leaves results alone; measuring is switched off first
    wr(`CQM_OFS_CFG, 32'h0);
    wr(`CQM_OFS_CFG, cfgw(1'b0, 1'b1, 1'b1, r[3:2] + 2'h1, 4'h0, 4'h0, 4'h0, 4'h0));
    check_cur();
    conclude();
  end
endmodule
